/* File: rtl/lpmc_pkg.sv */
// Constants, types and register map of the low power mode controller.
// Assumes a 25 MHz always-on controller clock and an Avalon-MM host.
// Function
// - Sleep halts the processor while all peripherals keep their clocks.
// - Sleep ends on reset or any enabled active interrupt.
// - Deep-sleep stops the main crystal oscillator and nearly all clocks.
// - Deep-sleep keeps the RC oscillator; watchdog on it may wake.
// - Deep-sleep keeps the RTC oscillator; RTC interrupts wake.
// - Deep-sleep puts flash in standby, not off, for quick wake.
// - Deep-sleep and power-down retain all state; all deep modes hold pin levels static.
// - Deep-sleep ends only on reset or clockless wake interrupts.
// - Power-down does all deep-sleep does and switches flash off.
// - Power-down wakes on any enabled source of the eleven listed.
// - Deep power-down powers off all but RTC, reset, wake logic, backup.
// - Software chooses whether the RTC oscillator stays powered in deep power-down.
// - Deep power-down ends on external reset or enabled RTC interrupt.
// - Sleep-on-exit sleeps on last handler return until next exception.
// - Wake logic uses hardware signals only, no registers; the deep-sleep watchdog wake is gated by ctrl_ff bit CTRL_WDT_IRC.
package lpmc_pkg;

  localparam int          MHZ            = 25;
  localparam int          CLK_STOP_NS    = 200;
  localparam int          PWR_SETTLE_NS  = 2000;
  localparam int          CLK_SETTLE_NS  = 400;
  localparam int          CNT_W          = 8;
  localparam logic [CNT_W-1:0] CLK_STOP_CYC   = CNT_W'((CLK_STOP_NS * MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] PWR_SETTLE_CYC = CNT_W'((PWR_SETTLE_NS * MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] CLK_SETTLE_CYC = CNT_W'((CLK_SETTLE_NS * MHZ + 999) / 1000);

  // Wake source positions
  localparam int NUM_WAKE   = 11;
  localparam int WK_NMI     = 0;
  localparam int WK_EXT_FST = 1;
  localparam int WK_EXT_LST = 4;
  localparam int WK_GPIO    = 5;
  localparam int WK_WOL     = 6;
  localparam int WK_BOD     = 7;
  localparam int WK_RTC     = 8;
  localparam int WK_USB     = 9;
  localparam int WK_CAN     = 10;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_STATE = 8'h04;
  localparam logic [7:0] OFF_ISTAT = 8'h08;
  localparam logic [7:0] OFF_IEN   = 8'h0C;
  localparam logic [7:0] OFF_ICLR  = 8'h10;

  localparam int CTRL_RTC_KEEP = 0;
  localparam int CTRL_WDT_IRC  = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int EV_WAKE  = 0;
  localparam int EV_ENTER = 1;
  localparam int NUM_EV   = 2;

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_DEEP_SLEEP,
    MODE_POWER_DOWN,
    MODE_DEEP_PD
  } lpmc_mode_type;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_GATE,
    ST_PWR_OFF,
    ST_DEEP,
    ST_PWR_ON,
    ST_CLK_ON
  } lpmc_state_type;

  typedef struct packed {
    logic cpu_halt;
    logic periph_clk;
    logic main_osc;
    logic internal_rc_oscillator;
    logic rtc_osc;
    logic flash_on;
    logic flash_stby;
    logic core_pwr;
    logic pin_hold;
  } lpmc_pwr_type;

  localparam lpmc_pwr_type PWR_RUN = 9'h0FA;

endpackage : lpmc_pkg

/* File: rtl/lpmc_sync.sv */
// Two-stage synchroniser, one per input bit.
// Assumes inputs are levels or pulses longer than two clock periods.
module lpmc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        meta_ff[i] <= 1'b0;
        sync_ff[i] <= 1'b0;
      end
      else
      begin
        meta_ff[i] <= d_in[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end

  assign q_out = sync_ff;

endmodule : lpmc_sync

/* File: rtl/lpmc_top.sv */
// Low power mode sequencer with Avalon-MM registers and one interrupt.
// Assumes CLOCK_IN stays alive in all modes (always-on domain) and that
// core request signals are synchronous to it; wake pins are not.
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
module lpmc_top (
  input  wire logic                  CLOCK_IN,
  input  wire logic                  RST_N_IN,
  input  wire logic [7:0]            ADDRESS_IN,
  input  wire logic                  READ_IN,
  input  wire logic                  WRITE_IN,
  input  wire logic [31:0]           WRITEDATA_IN,
  input  wire logic [3:0]            BYTEENABLE_IN,
  output logic      [31:0]           READDATA_OUT,
  output logic                       WAITREQUEST_OUT,
  input  wire logic                  SLEEP_REQ_IN,
  input  wire logic [1:0]            MODE_IN,
  input  wire logic                  SLEEP_ON_EXIT_IN,
  input  wire logic                  HANDLER_EXIT_IN,
  input  wire logic                  IRQ_PENDING_IN,
  input  wire logic [lpmc_pkg::NUM_WAKE-1:0] IRQ_ENABLE_IN,
  input  wire logic [lpmc_pkg::NUM_WAKE-1:0] WAKE_SRC_IN,
  input  wire logic                  WDT_EVENT_IN,
  input  wire logic                  RTC_INT_IN,
  output lpmc_pkg::lpmc_pwr_type     POWER_CTL_OUT,
  output logic                       IRQ_OUT
);

  localparam int SW = lpmc_pkg::NUM_WAKE + 2;

  lpmc_pkg::lpmc_state_type state_ff;
  lpmc_pkg::lpmc_state_type nxt_state;
  lpmc_pkg::lpmc_mode_type  mode_ff;
  lpmc_pkg::lpmc_mode_type  nxt_mode;
  lpmc_pkg::lpmc_pwr_type   pwr_ff;
  lpmc_pkg::lpmc_pwr_type   nxt_pwr;
  logic [lpmc_pkg::CNT_W-1:0] cnt_ff;
  logic [lpmc_pkg::CNT_W-1:0] nxt_cnt;
  logic [SW-1:0]            sync_w;
  logic [lpmc_pkg::NUM_WAKE-1:0] wake_src;
  logic                     wdt_ev;
  logic                     rtc_ev;
  logic                     enter_req;
  logic                     wake_hit;
  logic [1:0]               ctrl_ff;
  logic [lpmc_pkg::NUM_EV-1:0] stat_ff;
  logic [lpmc_pkg::NUM_EV-1:0] en_ff;
  logic [lpmc_pkg::NUM_EV-1:0] ev;
  logic [lpmc_pkg::NUM_EV-1:0] nxt_stat;
  logic                     wait_ff;
  logic [31:0]              rdata_ff;
  logic                     irq_ff;
  logic                     wr_go;
  logic                     req;

  // Pins and the RTC domain are asynchronous
  lpmc_sync #(
    .W (SW)
  ) u_sync (
    .clk_in   (CLOCK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     ({RTC_INT_IN, WDT_EVENT_IN, WAKE_SRC_IN}),
    .q_out    (sync_w)
  );

  assign wake_src = sync_w[lpmc_pkg::NUM_WAKE-1:0];
  assign wdt_ev   = sync_w[lpmc_pkg::NUM_WAKE];
  assign rtc_ev   = sync_w[lpmc_pkg::NUM_WAKE+1];

  assign enter_req = SLEEP_REQ_IN | (SLEEP_ON_EXIT_IN & HANDLER_EXIT_IN);

  // Pure combinational wake decode, only ctrl_ff bit CTRL_WDT_IRC is programmable here
  always_comb
  begin
    wake_hit = 1'b0;
    unique case (mode_ff)
      lpmc_pkg::MODE_SLEEP:
        wake_hit = IRQ_PENDING_IN;
      lpmc_pkg::MODE_DEEP_SLEEP:
        wake_hit = |(wake_src & IRQ_ENABLE_IN)
                   | (wdt_ev & ctrl_ff[lpmc_pkg::CTRL_WDT_IRC])
                   | rtc_ev;
      lpmc_pkg::MODE_POWER_DOWN:
        wake_hit = |(wake_src & IRQ_ENABLE_IN);
      lpmc_pkg::MODE_DEEP_PD:
        wake_hit = rtc_ev & IRQ_ENABLE_IN[lpmc_pkg::WK_RTC];
    endcase
  end

  // Power and clock controls implied by each state
  function automatic lpmc_pkg::lpmc_pwr_type pwr_for(
    input lpmc_pkg::lpmc_state_type st,
    input lpmc_pkg::lpmc_mode_type  md,
    input logic                     keep
  );
    lpmc_pkg::lpmc_pwr_type p;
    p = lpmc_pkg::PWR_RUN;
    unique case (st)
      lpmc_pkg::ST_RUN:
        p = lpmc_pkg::PWR_RUN;
      lpmc_pkg::ST_SLEEP:
        p.cpu_halt = 1'b1;
      lpmc_pkg::ST_GATE, lpmc_pkg::ST_PWR_OFF, lpmc_pkg::ST_DEEP:
      begin
        p.cpu_halt   = 1'b1;
        p.periph_clk = 1'b0;
        p.main_osc   = 1'b0;
        p.pin_hold   = 1'b1;
        p.flash_stby = 1'b1;
        if (st != lpmc_pkg::ST_GATE && md != lpmc_pkg::MODE_DEEP_SLEEP)
        begin
          p.flash_on   = 1'b0;
          p.flash_stby = 1'b0;
        end
        if (st != lpmc_pkg::ST_GATE && md == lpmc_pkg::MODE_DEEP_PD)
        begin
          p.core_pwr = 1'b0;
          p.internal_rc_oscillator      = 1'b0;
          p.rtc_osc  = keep;
        end
      end
      lpmc_pkg::ST_PWR_ON:
      begin
        p.cpu_halt   = 1'b1;
        p.periph_clk = 1'b0;
        p.pin_hold   = 1'b1;
      end
      lpmc_pkg::ST_CLK_ON:
      begin
        p.cpu_halt = 1'b1;
        p.pin_hold = 1'b1;
      end
    endcase
    return p;
  endfunction : pwr_for

  always_comb
  begin
    nxt_state = state_ff;
    nxt_mode  = mode_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      lpmc_pkg::ST_RUN:
        if (enter_req)
        begin
          nxt_mode = lpmc_pkg::lpmc_mode_type'(MODE_IN);
          if (nxt_mode == lpmc_pkg::MODE_SLEEP)
          begin
            nxt_state = lpmc_pkg::ST_SLEEP;
          end
          else
          begin
            nxt_state = lpmc_pkg::ST_GATE;
            nxt_cnt   = lpmc_pkg::CLK_STOP_CYC;
          end
        end
      lpmc_pkg::ST_SLEEP:
        if (wake_hit)
        begin
          nxt_state = lpmc_pkg::ST_RUN;
        end
      lpmc_pkg::ST_GATE:
        if (cnt_ff <= 1)
        begin
          nxt_state = lpmc_pkg::ST_PWR_OFF;
        end
        else
        begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      lpmc_pkg::ST_PWR_OFF:
        nxt_state = lpmc_pkg::ST_DEEP;
      lpmc_pkg::ST_DEEP:
        if (wake_hit)
        begin
          nxt_state = lpmc_pkg::ST_PWR_ON;
          nxt_cnt   = lpmc_pkg::PWR_SETTLE_CYC;
        end
      lpmc_pkg::ST_PWR_ON:
        if (cnt_ff <= 1)
        begin
          nxt_state = lpmc_pkg::ST_CLK_ON;
          nxt_cnt   = lpmc_pkg::CLK_SETTLE_CYC;
        end
        else
        begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      lpmc_pkg::ST_CLK_ON:
        if (cnt_ff <= 1)
        begin
          nxt_state = lpmc_pkg::ST_RUN;
        end
        else
        begin
          nxt_cnt = cnt_ff - 1'b1;
        end
    endcase
    nxt_pwr = pwr_for(nxt_state, nxt_mode, ctrl_ff[lpmc_pkg::CTRL_RTC_KEEP]);
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_ff <= lpmc_pkg::ST_RUN;
      mode_ff  <= lpmc_pkg::MODE_SLEEP;
      cnt_ff   <= '0;
      pwr_ff   <= lpmc_pkg::PWR_RUN;
    end
    else
    begin
      state_ff <= nxt_state;
      mode_ff  <= nxt_mode;
      cnt_ff   <= nxt_cnt;
      pwr_ff   <= nxt_pwr;
    end
  end

  // Avalon slave: every access answers one cycle after it is seen
  assign req   = READ_IN | WRITE_IN;
  assign wr_go = WRITE_IN & ~wait_ff & BYTEENABLE_IN[0];

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      wait_ff <= 1'b1;
    end
    else
    begin
      wait_ff <= ~(req & wait_ff);
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else if (READ_IN && wait_ff)
    begin
      unique case (ADDRESS_IN)
        lpmc_pkg::OFF_CTRL:  rdata_ff <= {30'h0000_0000, ctrl_ff};
        lpmc_pkg::OFF_STATE: rdata_ff <= {18'h0_0000, pwr_ff, mode_ff, state_ff};
        lpmc_pkg::OFF_ISTAT: rdata_ff <= {30'h0000_0000, stat_ff};
        lpmc_pkg::OFF_IEN:   rdata_ff <= {30'h0000_0000, en_ff};
        default:             rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ctrl_ff <= lpmc_pkg::CTRL_RST;
      en_ff   <= '0;
    end
    else if (wr_go)
    begin
      if (ADDRESS_IN == lpmc_pkg::OFF_CTRL)
      begin
        ctrl_ff <= WRITEDATA_IN[1:0];
      end
      if (ADDRESS_IN == lpmc_pkg::OFF_IEN)
      begin
        en_ff <= WRITEDATA_IN[lpmc_pkg::NUM_EV-1:0];
      end
    end
  end

  // Set beats a clear in the same cycle
  assign ev[lpmc_pkg::EV_WAKE]  = (nxt_state == lpmc_pkg::ST_RUN)
                                  && (state_ff != lpmc_pkg::ST_RUN);
  assign ev[lpmc_pkg::EV_ENTER] = (nxt_state == lpmc_pkg::ST_SLEEP
                                   || nxt_state == lpmc_pkg::ST_DEEP)
                                  && (nxt_state != state_ff);

  always_comb
  begin
    nxt_stat = stat_ff;
    if (wr_go && ADDRESS_IN == lpmc_pkg::OFF_ICLR)
    begin
      nxt_stat = stat_ff & ~WRITEDATA_IN[lpmc_pkg::NUM_EV-1:0];
    end
    nxt_stat = nxt_stat | ev;
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      stat_ff <= '0;
      irq_ff  <= 1'b0;
    end
    else
    begin
      stat_ff <= nxt_stat;
      irq_ff  <= |(nxt_stat & en_ff);
    end
  end

  assign READDATA_OUT    = rdata_ff;
  assign WAITREQUEST_OUT = wait_ff;
  assign POWER_CTL_OUT   = pwr_ff;
  assign IRQ_OUT         = irq_ff;

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  sequence s_enter_deep;
    state_ff == lpmc_pkg::ST_RUN ##1 state_ff == lpmc_pkg::ST_GATE;
  endsequence

  sequence s_leave_deep;
    state_ff == lpmc_pkg::ST_DEEP ##1 state_ff == lpmc_pkg::ST_PWR_ON;
  endsequence

  a_sleep_halt: assert property (
    state_ff == lpmc_pkg::ST_SLEEP |-> pwr_ff.cpu_halt && pwr_ff.periph_clk)
    else $error("Sleep must halt core and keep peripheral clock");

  a_sleep_wake: assert property (
    state_ff == lpmc_pkg::ST_SLEEP && IRQ_PENDING_IN
      |=> state_ff == lpmc_pkg::ST_RUN && !pwr_ff.cpu_halt)
    else $error("Sleep did not end on pending interrupt");

  a_deep_clocks: assert property (
    state_ff == lpmc_pkg::ST_DEEP |-> !pwr_ff.main_osc && !pwr_ff.periph_clk)
    else $error("Main oscillator or clocks alive in deep state");

  a_ds_keep: assert property (
    state_ff == lpmc_pkg::ST_DEEP && mode_ff == lpmc_pkg::MODE_DEEP_SLEEP
      |-> pwr_ff.flash_on && pwr_ff.flash_stby && pwr_ff.internal_rc_oscillator && pwr_ff.rtc_osc)
    else $error("Deep-sleep lost flash standby or oscillators");

  a_ds_wdt_wake: assert property (
    state_ff == lpmc_pkg::ST_DEEP && mode_ff == lpmc_pkg::MODE_DEEP_SLEEP
      && wdt_ev && ctrl_ff[lpmc_pkg::CTRL_WDT_IRC] |=> state_ff == lpmc_pkg::ST_PWR_ON)
    else $error("Watchdog on RC clock failed to wake");

  a_pins_held: assert property (
    state_ff inside {lpmc_pkg::ST_GATE, lpmc_pkg::ST_PWR_OFF, lpmc_pkg::ST_DEEP,
                     lpmc_pkg::ST_PWR_ON, lpmc_pkg::ST_CLK_ON} |-> pwr_ff.pin_hold)
    else $error("Pins not held during deep mode");

  a_stay_asleep: assert property (
    state_ff == lpmc_pkg::ST_DEEP && !wake_hit |=> state_ff == lpmc_pkg::ST_DEEP)
    else $error("Left deep state without a wake source");

  a_pd_flash: assert property (
    state_ff == lpmc_pkg::ST_DEEP && mode_ff == lpmc_pkg::MODE_POWER_DOWN
      |-> !pwr_ff.flash_on && !pwr_ff.flash_stby && !pwr_ff.main_osc)
    else $error("Flash still powered in power-down");

  a_dpd_off: assert property (
    state_ff == lpmc_pkg::ST_DEEP && mode_ff == lpmc_pkg::MODE_DEEP_PD
      |-> !pwr_ff.core_pwr && pwr_ff.rtc_osc == ctrl_ff[lpmc_pkg::CTRL_RTC_KEEP])
    else $error("Deep power-down power state wrong");

  a_soe_entry: assert property (
    state_ff == lpmc_pkg::ST_RUN && SLEEP_ON_EXIT_IN && HANDLER_EXIT_IN
      |=> state_ff inside {lpmc_pkg::ST_SLEEP, lpmc_pkg::ST_GATE})
    else $error("Sleep-on-exit did not enter low power");

  a_gate_first: assert property (
    s_enter_deep |-> !pwr_ff.periph_clk && pwr_ff.core_pwr && pwr_ff.flash_on)
    else $error("Power removed before clocks gated");

  a_power_first: assert property (
    s_leave_deep |-> !pwr_ff.periph_clk ##50 state_ff == lpmc_pkg::ST_CLK_ON
      && pwr_ff.periph_clk ##10 state_ff == lpmc_pkg::ST_RUN)
    else $error("Wake order or settle time wrong");

endmodule : lpmc_top

/* File: sim/lpmc_core_model.sv */
// Processor core and interrupt controller model on the request side.
// Assumes the controller clock and the halt and clock fields of its power struct.
module lpmc_core_model (
  input  wire logic        clk_in,
  input  wire logic        halt_in,
  input  wire logic        pclk_in,
  input  wire logic        pirq_in,
  output logic             req_out,
  output logic [1:0]       mode_out,
  output logic             soe_out,
  output logic             hexit_out,
  output logic             pend_out,
  output logic [10:0]      en_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    req_out = 1'b0;
    mode_out = 2'h0;
    soe_out = 1'b0;
    hexit_out = 1'b0;
    en_out = 11'h000;
  end

  // Peripheral interrupts need a running peripheral clock
  always_ff @(posedge clk_in)
    pend_out <= pirq_in & pclk_in;

  task automatic request(input logic [1:0] m);
    @(posedge clk_in);
    if (halt_in === 1'b0)
    begin
      req_out <= 1'b1;
      mode_out <= m;
    end
    @(posedge clk_in);
    req_out <= 1'b0;
  endtask : request

  task automatic cfg(input logic s, input logic [10:0] e);
    @(posedge clk_in);
    soe_out <= s;
    en_out <= e;
  endtask : cfg

  task automatic hret();
    @(posedge clk_in);
    hexit_out <= 1'b1;
    @(posedge clk_in);
    hexit_out <= 1'b0;
  endtask : hret
endmodule : lpmc_core_model

/* File: sim/lpmc_tb.sv */
// Self-checking bench for the low power mode controller.
// Assumes the core model beside it and the rtl package.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clk, rst_n, rd, wr, wdt, rtc, pirq, kp;
  logic                   wreq, sreq, soe, hexit, pend, irq;
  logic [1:0]             mode;
  logic [3:0]             be;
  logic [7:0]             addr;
  logic [10:0]            wsrc, en;
  logic [31:0]            wdata, rdata, q;
  lpmc_pkg::lpmc_pwr_type p;
  int                     bad_count, n_compared, seed, i, j, k;

  always #20 clk = !clk;

  lpmc_top dut_u (
    .CLOCK_IN         (clk),
    .RST_N_IN         (rst_n),
    .ADDRESS_IN       (addr),
    .READ_IN          (rd),
    .WRITE_IN         (wr),
    .WRITEDATA_IN     (wdata),
    .BYTEENABLE_IN    (be),
    .READDATA_OUT     (rdata),
    .WAITREQUEST_OUT  (wreq),
    .SLEEP_REQ_IN     (sreq),
    .MODE_IN          (mode),
    .SLEEP_ON_EXIT_IN (soe),
    .HANDLER_EXIT_IN  (hexit),
    .IRQ_PENDING_IN   (pend),
    .IRQ_ENABLE_IN    (en),
    .WAKE_SRC_IN      (wsrc),
    .WDT_EVENT_IN     (wdt),
    .RTC_INT_IN       (rtc),
    .POWER_CTL_OUT    (p),
    .IRQ_OUT          (irq)
  );

  lpmc_core_model core_u (
    .clk_in    (clk),
    .halt_in   (p.cpu_halt),
    .pclk_in   (p.periph_clk),
    .pirq_in   (pirq),
    .req_out   (sreq),
    .mode_out  (mode),
    .soe_out   (soe),
    .hexit_out (hexit),
    .pend_out  (pend),
    .en_out    (en)
  );

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic cb(input string s, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %b seen %b", s, e, g);
    end
  endtask : cb

  task automatic cw(input string s, input logic [31:0] e);
    n_compared++;
    if (q !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, e, q);
    end
  endtask : cw

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    be <= b;
    // Waitrequest and read data are taken as they stood at the rising edge
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (wreq === 1'b0)
        break;
    end
    if (n == 20)
      cb("bus answer", 1'b0, 1'b1);
    if (n == 20)
      stop_test();
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic drv(input logic [10:0] s, input logic w, input logic r, input logic i);
    @(posedge clk);
    wsrc <= s;
    wdt <= w;
    rtc <= r;
    pirq <= i;
  endtask : drv

  task automatic enter(input logic [1:0] m);
    core_u.request(m);
    repeat (2) @(negedge clk);
    if (m != 2'h0)
      cb("gate first", 1'b1, p.core_pwr & !p.periph_clk);
    repeat (10) @(negedge clk);
  endtask : enter

  task automatic hold(input string s);
    repeat (20) @(negedge clk);
    cb(s, 1'b1, p.cpu_halt);
  endtask : hold

  // Power and oscillators settle before clocks, clocks before the core
  task automatic wt(input bit dp);
    int n;
    for (n = 0; n < 100 && p.cpu_halt !== 1'b0; n++)
    begin
      @(negedge clk);
      if (dp && n == 30)
        cb("power before clocks", 1'b1, p.core_pwr & p.main_osc & !p.periph_clk);
    end
    if (n == 100)
      cb("wake", 1'b0, 1'b1);
    if (n == 100)
      stop_test();
    if (dp)
      cb("deep wake time", 1'b1, n >= 60 && n < 70);
    else
      cb("sleep wake time", 1'b1, n < 6);
    drv(11'h000, 1'b0, 1'b0, 1'b0);
  endtask : wt

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {rd, wr, wdt, rtc, pirq} = 5'h00;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    be = 4'h0;
    wsrc = 11'h000;
    seed = 63255;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cb("reset halt", 1'b0, p.cpu_halt);
    cb("reset irq", 1'b0, irq);
    bus(1'b0, lpmc_pkg::OFF_CTRL, 32'h0000_0000, 4'hF);
    cw("ctrl reset", 32'h0000_0001);
    bus(1'b0, 8'h40, 32'h0000_0000, 4'hF);
    cw("unmapped", 32'h0000_0000);
    bus(1'b0, lpmc_pkg::OFF_STATE, 32'h0000_0000, 4'hF);
    cw("state reset", {18'h0_0000, lpmc_pkg::PWR_RUN, 5'h00});
    bus(1'b1, lpmc_pkg::OFF_CTRL, 32'h0000_0000, 4'h0);
    bus(1'b0, lpmc_pkg::OFF_CTRL, 32'h0000_0000, 4'hF);
    cw("byte lane off", 32'h0000_0001);
    bus(1'b1, lpmc_pkg::OFF_IEN, 32'h0000_0002, 4'hF);
    $display("test registers done");
    enter(lpmc_pkg::MODE_SLEEP);
    cb("sleep halt", 1'b1, p.cpu_halt);
    cb("sleep pclk", 1'b1, p.periph_clk);
    cb("irq raised", 1'b1, irq);
    bus(1'b1, lpmc_pkg::OFF_IEN, 32'h0000_0000, 4'hF);
    repeat (2) @(negedge clk);
    cb("irq masked", 1'b0, irq);
    drv(11'h000, 1'b0, 1'b0, 1'b1);
    wt(1'b0);
    core_u.cfg(1'b1, 11'h000);
    core_u.hret();
    repeat (3) @(negedge clk);
    cb("exit sleep", 1'b1, p.cpu_halt);
    drv(11'h000, 1'b0, 1'b0, 1'b1);
    wt(1'b0);
    core_u.cfg(1'b0, 11'h000);
    $display("test sleep done");
    bus(1'b1, lpmc_pkg::OFF_CTRL, 32'h0000_0001, 4'hF);
    enter(lpmc_pkg::MODE_DEEP_SLEEP);
    cb("ds osc", 1'b0, p.main_osc);
    cb("ds pclk", 1'b0, p.periph_clk);
    cb("ds irc", 1'b1, p.internal_rc_oscillator);
    cb("ds rtc osc", 1'b1, p.rtc_osc);
    cb("ds standby", 1'b1, p.flash_stby);
    cb("ds flash", 1'b1, p.flash_on);
    cb("ds pins", 1'b1, p.pin_hold);
    drv(11'h000, 1'b1, 1'b0, 1'b1);
    hold("ds no wake");
    drv(11'h000, 1'b0, 1'b1, 1'b0);
    wt(1'b1);
    bus(1'b1, lpmc_pkg::OFF_CTRL, 32'h0000_0003, 4'hF);
    enter(lpmc_pkg::MODE_DEEP_SLEEP);
    drv(11'h000, 1'b1, 1'b0, 1'b0);
    wt(1'b1);
    bus(1'b0, lpmc_pkg::OFF_CTRL, 32'h0000_0000, 4'hF);
    cw("ctrl kept", 32'h0000_0003);
    $display("test deep-sleep done");
    for (i = 0; i < 11; i++)
    begin
      j = (i + 1 + ($unsigned($random(seed)) % 10)) % 11;
      core_u.cfg(1'b0, 11'(1 << i));
      enter(lpmc_pkg::MODE_POWER_DOWN);
      cb("pd flash", 1'b0, p.flash_on);
      cb("pd standby", 1'b0, p.flash_stby);
      cb("pd osc", 1'b0, p.main_osc);
      drv(11'(1 << j), 1'b0, 1'b0, 1'b0);
      hold("pd disabled source");
      drv(11'(1 << i), 1'b0, 1'b0, 1'b0);
      wt(1'b1);
    end
    $display("test power-down done");
    for (k = 0; k < 2; k++)
    begin
      kp = 1'(k) ^ 1'($random(seed));
      bus(1'b1, lpmc_pkg::OFF_CTRL, {31'h0000_0000, kp}, 4'hF);
      core_u.cfg(1'b0, 11'h6FF);
      enter(lpmc_pkg::MODE_DEEP_PD);
      cb("dpd core", 1'b0, p.core_pwr);
      cb("dpd irc", 1'b0, p.internal_rc_oscillator);
      cb("dpd rtc osc", kp, p.rtc_osc);
      drv(11'h001, 1'b0, 1'b1, 1'b0);
      hold("dpd rtc disabled");
      core_u.cfg(1'b0, 11'h100);
      wt(1'b1);
    end
    $display("test deep power-down done");
    bus(1'b1, lpmc_pkg::OFF_IEN, 32'h0000_0003, 4'hF);
    bus(1'b0, lpmc_pkg::OFF_ISTAT, 32'h0000_0000, 4'hF);
    cw("status", 32'h0000_0003);
    cb("irq enabled", 1'b1, irq);
    bus(1'b1, lpmc_pkg::OFF_ICLR, 32'h0000_0003, 4'hF);
    bus(1'b0, lpmc_pkg::OFF_ISTAT, 32'h0000_0000, 4'hF);
    cw("status cleared", 32'h0000_0000);
    cb("irq cleared", 1'b0, irq);
    $display("test interrupt done");
    stop_test();
  end
endmodule : tb
